// file: smh_pkg.sv
package smh_pkg;
	// Clock and timing: least times round up to whole cycles
	localparam int CLK_PERIOD_NS = 20;
	localparam int STROBE_NS = 100;
	localparam int EOP_OVERLAP_NS = 100;
	localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] EOP_CYC = 4'((EOP_OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Device port numbers on the address pins
	localparam logic [2:0] PORT_DATA = 3'h0;
	localparam logic [2:0] PORT_ICR = 3'h1;
	localparam logic [2:0] PORT_OPERATING_CONTROL = 3'h2;
	localparam logic [2:0] PORT_TARGET_PHASE_COMMAND = 3'h3;
	localparam logic [2:0] PORT_BUS_SIGNAL_STATUS = 3'h4;
	localparam logic [2:0] PORT_SEND_TRANSFER_START = 3'h5;
	localparam logic [2:0] PORT_TARGET_RECEIVE_START = 3'h6;
	localparam logic [2:0] PORT_INITIATOR_RECEIVE_START = 3'h7;

	// Operating control and initiator command fields, and the start port data byte
	localparam int MODE_BURST_DMA_SELECT = 7;
	localparam int MODE_TARGET_ROLE_SELECT = 6;
	localparam int MODE_PARITY_CHECK_ENABLE = 5;
	localparam int MODE_PARITY_IRQ_ENABLE = 4;
	localparam int MODE_TRANSFER_END_IRQ_ENABLE = 3;
	localparam int MODE_BUSY_LOSS_WATCH = 2;
	localparam int MODE_DMA_ENABLE = 1;
	localparam int MODE_ARBITRATION_REQUEST = 0;
	localparam int ICR_DRIVE_DATA_LINES = 0;
	localparam int ICR_ARBITRATION_LOST = 5;
	localparam int ICR_ARBITRATION_ACTIVE = 6;
	localparam logic [7:0] START_PORT_DATA = 8'h00;

	// Bus phase codes, I/O then C/D then MSG from high bit to low
	typedef enum logic [2:0] {
		PH_DATA_OUT = 3'h0,
		PH_UNSPEC_A = 3'h1,
		PH_COMMAND = 3'h2,
		PH_MSG_OUT = 3'h3,
		PH_DATA_IN = 3'h4,
		PH_UNSPEC_B = 3'h5,
		PH_STATUS = 3'h6,
		PH_MSG_IN = 3'h7
	} smh_phase_e;

	// Controller register map on the software port
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_DEV_WDATA = 4'h1;
	localparam logic [3:0] REG_DEV_RDATA = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_DMA_COUNT = 4'h4;
	localparam logic [3:0] REG_DMA_WDATA = 4'h5;
	localparam logic [3:0] REG_DMA_RDATA = 4'h6;
	localparam logic [3:0] REG_HOST_CTRL = 4'h7;
	localparam int CMD_READ_BIT = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_IRQ = 2;
	localparam int STAT_DRQ = 3;
	localparam int STAT_DMA = 4;
	localparam int HOST_CTRL_RESET = 0;

	// Sequencer states, Gray coded along the access path but not along the byte path
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SETUP = 3'b001,
		S_STROBE = 3'b011,
		S_HOLD = 3'b010,
		S_DWAIT = 3'b110,
		S_DSTROBE = 3'b111,
		S_DHOLD = 3'b101
	} smh_state_e;
endpackage

// file: smh_scsi_host.sv
`timescale 1ns/10ps
module smh_scsi_host #(
	parameter int CNT_W = 8
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [3:0] sw_addr_i,
	input wire logic [7:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [7:0] sw_rdata_o,
	output logic dev_cs_n_o,
	output logic [2:0] dev_addr_o,
	output logic read_strobe_n_o,
	output logic write_strobe_n_o,
	input wire logic [7:0] dev_data_i,
	output logic [7:0] dev_data_o,
	output logic dev_data_oe_o,
	input wire logic dma_req_i,
	output logic dma_ack_n_o,
	output logic transfer_end_n_o,
	input wire logic dev_ready_i,
	input wire logic dev_irq_i,
	output logic dev_reset_n_o
);
	import smh_pkg::*;

	smh_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic acc_rd, next_acc_rd;
	logic [2:0] acc_port, next_acc_port;
	logic [7:0] dev_wdata, next_dev_wdata;
	logic [7:0] dev_rdata, next_dev_rdata;
	logic refused, next_refused;
	logic [CNT_W-1:0] dma_count, next_dma_count;
	logic [7:0] dma_wdata, next_dma_wdata;
	logic [7:0] dma_rdata, next_dma_rdata;
	logic dma_armed, next_dma_armed;
	logic dma_send, next_dma_send;
	logic [7:0] shadow_mode, next_shadow_mode;
	logic [7:0] shadow_icr, next_shadow_icr;
	logic host_rst, next_host_rst;
	logic [7:0] sw_rdata, next_sw_rdata;
	logic cs_n, next_cs_n;
	logic [2:0] addr, next_addr;
	logic rd_n, next_rd_n;
	logic wr_n, next_wr_n;
	logic [7:0] dout, next_dout;
	logic oe, next_oe;
	logic dma_ack_in_n, next_dma_ack_in_n;
	logic eop_n, next_eop_n;
	logic cmd_wr;
	logic cmd_ok;
	logic last_byte;
	logic byte_go;

	// Guard on device accesses; refused ones never reach the pins
	function automatic logic access_legal(input logic rd, input logic [2:0] port,
			input logic [7:0] data, input logic [7:0] mode, input logic [7:0] icr);
		logic ok;
		ok = 1'b1;
		if (!rd && port >= PORT_SEND_TRANSFER_START && !mode[MODE_DMA_ENABLE]) begin
			ok = 1'b0;
		end
		if (!rd && port == PORT_SEND_TRANSFER_START && !icr[ICR_DRIVE_DATA_LINES]) begin
			ok = 1'b0;
		end
		if (!rd && port == PORT_TARGET_RECEIVE_START && !mode[MODE_TARGET_ROLE_SELECT]) begin
			ok = 1'b0;
		end
		if (!rd && port == PORT_INITIATOR_RECEIVE_START && mode[MODE_TARGET_ROLE_SELECT]) begin
			ok = 1'b0;
		end
		if (!rd && port == PORT_TARGET_PHASE_COMMAND && (smh_phase_e'(data[2:0]) == PH_UNSPEC_A
				|| smh_phase_e'(data[2:0]) == PH_UNSPEC_B)) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// Strobe length for a byte; the last byte keeps the end marker long enough
	function automatic logic [3:0] hold_cycles(input logic with_end);
		logic [3:0] n;
		n = STROBE_CYC;
		if (with_end && EOP_CYC > STROBE_CYC) begin
			n = EOP_CYC;
		end
		if (n == 4'h0) begin
			n = 4'h1;
		end
		return n - 4'h1;
	endfunction

	assign cmd_wr = sw_wr_i && sw_addr_i == REG_CMD;
	assign cmd_ok = access_legal(sw_wdata_i[CMD_READ_BIT], sw_wdata_i[2:0], dev_wdata,
		shadow_mode, shadow_icr);
	assign last_byte = dma_count == CNT_W'(1);
	// Burst mode paces on ready once the byte run has begun; normal mode on request
	assign byte_go = shadow_mode[MODE_BURST_DMA_SELECT] ?
		(dev_ready_i && (dma_req_i || !dma_ack_in_n)) : dma_req_i;

	// Next values of the sequencer, the register file and the pin flops
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_acc_rd = acc_rd;
		next_acc_port = acc_port;
		next_dev_wdata = dev_wdata;
		next_dev_rdata = dev_rdata;
		next_refused = refused;
		next_dma_count = dma_count;
		next_dma_wdata = dma_wdata;
		next_dma_rdata = dma_rdata;
		next_dma_armed = dma_armed;
		next_dma_send = dma_send;
		next_shadow_mode = shadow_mode;
		next_shadow_icr = shadow_icr;
		next_host_rst = host_rst;
		next_sw_rdata = 8'h00;
		next_cs_n = cs_n;
		next_addr = addr;
		next_rd_n = rd_n;
		next_wr_n = wr_n;
		next_dout = dout;
		next_oe = oe;
		next_dma_ack_in_n = dma_ack_in_n;
		next_eop_n = eop_n;

		// Plain register writes from software
		if (sw_wr_i) begin
			unique case (sw_addr_i)
				REG_DEV_WDATA: next_dev_wdata = sw_wdata_i;
				REG_DMA_COUNT: next_dma_count = CNT_W'(sw_wdata_i);
				REG_DMA_WDATA: next_dma_wdata = sw_wdata_i;
				REG_HOST_CTRL: next_host_rst = sw_wdata_i[HOST_CTRL_RESET];
				default: ;
			endcase
		end

		// Read data stands only in the cycle after the read strobe
		if (sw_rd_i) begin
			unique case (sw_addr_i)
				REG_DEV_WDATA: next_sw_rdata = dev_wdata;
				REG_DEV_RDATA: next_sw_rdata = dev_rdata;
				REG_STATUS: begin
					next_sw_rdata[STAT_BUSY] = state != S_IDLE;
					next_sw_rdata[STAT_REFUSED] = refused;
					next_sw_rdata[STAT_IRQ] = dev_irq_i;
					next_sw_rdata[STAT_DRQ] = dma_req_i;
					next_sw_rdata[STAT_DMA] = dma_armed;
					next_refused = 1'b0;
				end
				REG_DMA_COUNT: next_sw_rdata = 8'(dma_count);
				REG_DMA_WDATA: next_sw_rdata = dma_wdata;
				REG_DMA_RDATA: next_sw_rdata = dma_rdata;
				REG_HOST_CTRL: next_sw_rdata[HOST_CTRL_RESET] = host_rst;
				default: ;
			endcase
		end

		// Device access command, taken only between bytes so no byte is cut short
		if (cmd_wr) begin
			if ((state == S_IDLE || state == S_DWAIT) && cmd_ok) begin
				next_acc_rd = sw_wdata_i[CMD_READ_BIT];
				next_acc_port = sw_wdata_i[2:0];
				next_addr = sw_wdata_i[2:0];
				next_dma_ack_in_n = 1'b1; // acknowledge drops before select
				next_state = S_SETUP;
			end else begin
				next_refused = 1'b1; // Set wins over the status read clear
			end
		end else begin
			unique case (state)
				S_IDLE: begin
					if (dma_armed && dma_count != '0) begin
						next_state = S_DWAIT; // no per-byte software action
					end
				end
				S_SETUP: begin
					next_cs_n = 1'b0;
					next_rd_n = !acc_rd;
					next_wr_n = acc_rd;
					next_oe = !acc_rd;
					next_dout = acc_port >= PORT_SEND_TRANSFER_START ?
						START_PORT_DATA : dev_wdata;
					next_cnt = hold_cycles(1'b0);
					next_state = S_STROBE;
				end
				S_STROBE: begin
					if (cnt == 4'h0) begin
						next_rd_n = 1'b1;
						next_wr_n = 1'b1;
						if (acc_rd) begin
							next_dev_rdata = dev_data_i;
							// Port 2 read reloads the mode shadow from the device
							if (acc_port == PORT_OPERATING_CONTROL) begin
								next_shadow_mode = dev_data_i; // Sees device clear
							end
						end else begin
							if (acc_port == PORT_OPERATING_CONTROL) begin
								next_shadow_mode = dev_wdata;
								if (!dev_wdata[MODE_DMA_ENABLE]) begin
									next_dma_armed = 1'b0;
								end
							end
							if (acc_port == PORT_ICR) begin
								next_shadow_icr = dev_wdata;
							end
							if (acc_port >= PORT_SEND_TRANSFER_START) begin
								next_dma_armed = 1'b1;
								next_dma_send = acc_port == PORT_SEND_TRANSFER_START;
							end
						end
						next_state = S_HOLD;
					end else begin
						next_cnt = cnt - 4'h1;
					end
				end
				S_HOLD: begin
					next_cs_n = 1'b1;
					next_oe = 1'b0;
					next_state = S_IDLE;
				end
				S_DWAIT: begin
					if (!dma_armed || dma_count == '0) begin
						next_dma_ack_in_n = 1'b1;
						next_dma_armed = 1'b0;
						next_state = S_IDLE;
					end else if (byte_go) begin
						next_dma_ack_in_n = 1'b0;
						next_rd_n = dma_send;
						next_wr_n = !dma_send;
						next_oe = dma_send;
						next_dout = dma_wdata;
						next_eop_n = !last_byte;
						next_cnt = hold_cycles(last_byte);
						next_state = S_DSTROBE;
					end
				end
				S_DSTROBE: begin
					if (cnt == 4'h0) begin
						// Strobe trailing edge ends the byte in burst mode
						next_rd_n = 1'b1;
						next_wr_n = 1'b1;
						next_eop_n = 1'b1;
						if (!dma_send) begin
							next_dma_rdata = dev_data_i;
						end
						next_dma_count = dma_count - CNT_W'(1);
						next_state = S_DHOLD;
					end else begin
						next_cnt = cnt - 4'h1;
					end
				end
				S_DHOLD: begin
					next_oe = 1'b0;
					// Acknowledge rising edge ends the byte in normal mode
					if (!shadow_mode[MODE_BURST_DMA_SELECT] || dma_count == '0) begin
						next_dma_ack_in_n = 1'b1;
					end
					if (dma_count == '0) begin
						// Device keeps its DMA enable; software clears it
						next_dma_armed = 1'b0;
						next_state = S_IDLE;
					end else begin
						next_state = S_DWAIT;
					end
				end
				default: next_state = S_IDLE;
			endcase
		end
	end

	// Register stage; clock enable low freezes everything
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= S_IDLE;
			cnt <= 4'h0;
			acc_rd <= 1'b0;
			acc_port <= 3'h0;
			dev_wdata <= 8'h00;
			dev_rdata <= 8'h00;
			refused <= 1'b0;
			dma_count <= '0;
			dma_wdata <= 8'h00;
			dma_rdata <= 8'h00;
			dma_armed <= 1'b0;
			dma_send <= 1'b0;
			shadow_mode <= 8'h00;
			shadow_icr <= 8'h00;
			host_rst <= 1'b0;
			sw_rdata <= 8'h00;
			cs_n <= 1'b1;
			addr <= 3'h0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			dout <= 8'h00;
			oe <= 1'b0;
			dma_ack_in_n <= 1'b1;
			eop_n <= 1'b1;
		end else if (ce_i) begin
			state <= next_state;
			cnt <= next_cnt;
			acc_rd <= next_acc_rd;
			acc_port <= next_acc_port;
			dev_wdata <= next_dev_wdata;
			dev_rdata <= next_dev_rdata;
			refused <= next_refused;
			dma_count <= next_dma_count;
			dma_wdata <= next_dma_wdata;
			dma_rdata <= next_dma_rdata;
			dma_armed <= next_dma_armed;
			dma_send <= next_dma_send;
			shadow_mode <= next_shadow_mode;
			shadow_icr <= next_shadow_icr;
			host_rst <= next_host_rst;
			sw_rdata <= next_sw_rdata;
			cs_n <= next_cs_n;
			addr <= next_addr;
			rd_n <= next_rd_n;
			wr_n <= next_wr_n;
			dout <= next_dout;
			oe <= next_oe;
			dma_ack_in_n <= next_dma_ack_in_n;
			eop_n <= next_eop_n;
		end
	end

	// Every output but dev_reset_n_o straight from a flop
	assign sw_rdata_o = sw_rdata;
	assign dev_cs_n_o = cs_n;
	assign dev_addr_o = addr;
	assign read_strobe_n_o = rd_n;
	assign write_strobe_n_o = wr_n;
	assign dev_data_o = dout;
	assign dev_data_oe_o = oe;
	assign dma_ack_n_o = dma_ack_in_n;
	assign transfer_end_n_o = eop_n;
	assign dev_reset_n_o = !host_rst; // Inverter on a flop; no logic beyond it
endmodule

// file: smh_scsi_host_asserts.sv
`timescale 1ns/10ps
module smh_scsi_host_asserts import smh_pkg::*; (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic dev_cs_n_o,
	input wire logic [2:0] dev_addr_o,
	input wire logic read_strobe_n_o,
	input wire logic write_strobe_n_o,
	input wire logic [7:0] dev_data_o,
	input wire logic dev_data_oe_o,
	input wire logic dma_ack_n_o,
	input wire logic transfer_end_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// Pin level relations on the device side
	a_cs_dma_ack_in_excl: assert property (dev_cs_n_o || dma_ack_n_o)
		else $error("select and acknowledge low together");
	a_strobe_excl: assert property (read_strobe_n_o || write_strobe_n_o)
		else $error("both strobes low");
	a_wr_width: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*5] ##1 write_strobe_n_o)
		else $error("write strobe width wrong");
	a_rd_width: assert property ($fell(read_strobe_n_o) |-> !read_strobe_n_o [*5] ##1 read_strobe_n_o)
		else $error("read strobe width wrong");
	a_end_overlap: assert property ($fell(transfer_end_n_o) |-> (!transfer_end_n_o && !dma_ack_n_o && !(read_strobe_n_o && write_strobe_n_o)) [*5] ##1 transfer_end_n_o)
		else $error("transfer end overlap wrong");
	a_dma_ack_in_after: assert property ($rose(dma_ack_n_o) |-> $past(read_strobe_n_o) && $past(write_strobe_n_o))
		else $error("acknowledge released inside strobe");
	a_start_zero: assert property ((!dev_cs_n_o && !write_strobe_n_o && dev_addr_o >= PORT_SEND_TRANSFER_START) |-> dev_data_o == START_PORT_DATA)
		else $error("start port data not zero");
	a_send_drive: assert property (!write_strobe_n_o |-> dev_data_oe_o)
		else $error("data not driven during write");
	a_recv_float: assert property (!read_strobe_n_o |-> !dev_data_oe_o)
		else $error("data driven during read");
	a_addr_hold: assert property (!dev_cs_n_o |-> $stable(dev_addr_o))
		else $error("port number moved under select");
	// Main traffic kinds
	c_end: cover property ($fell(transfer_end_n_o));
	c_send: cover property (!dma_ack_n_o && !write_strobe_n_o);
	c_recv: cover property (!dma_ack_n_o && !read_strobe_n_o);
endmodule

// file: smh_dev_model.sv
`timescale 1ns/10ps
module smh_dev_model import smh_pkg::*; #(
	parameter logic [7:0] RX_BYTE = 8'hC3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic [2:0] addr_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic drq_o,
	input wire logic dma_ack_in_n_i,
	input wire logic eop_n_i,
	output logic ready_o,
	output logic irq_o
);
	logic [7:0] mode = 8'h00, icr = 8'h00, tcmd = 8'h00, sel_mask = 8'h00, last_wr = 8'h00;
	logic [7:0] rval, bytes = 8'h00;
	logic [3:0] eop_cnt = 4'h0;
	logic rd_q = 1'b1, wr_q = 1'b1, dk_q = 1'b1, act = 1'b0, end_flag = 1'b0, eop_act, byte_end;
	int acc_cnt = 0;
	initial data_o = 8'h00;
	initial drq_o = 1'b0;
	initial irq_o = 1'b0;
	// Byte ends on acknowledge rise, or on strobe end in burst mode
	assign byte_end = mode[MODE_BURST_DMA_SELECT] ? (!dma_ack_in_n_i && ((!wr_q && wr_n_i) || (!rd_q && rd_n_i))) : (!dk_q && dma_ack_in_n_i);
	assign eop_act = !eop_n_i && !dma_ack_in_n_i && !(rd_n_i && wr_n_i);
	assign ready_o = act && rd_n_i && wr_n_i;
	// Read mux; bit 3 reports a permanent phase agreement since no bus is modelled
	always_comb begin
		case (addr_i)
			3'h1: rval = icr;
			3'h2: rval = mode;
			3'h3: rval = tcmd;
			3'h5: rval = {end_flag, drq_o, 1'b0, irq_o, 1'b1, 3'h0};
			default: rval = RX_BYTE;
		endcase
	end
	// Device behaviour sampled on the host clock; released data bus toggles
	always @(posedge clk_i) begin
		rd_q <= rd_n_i;
		wr_q <= wr_n_i;
		dk_q <= dma_ack_in_n_i;
		data_o <= (!rd_n_i && (!cs_n_i || !dma_ack_in_n_i)) ? (cs_n_i ? RX_BYTE : rval) : ~data_o;
		eop_cnt <= eop_act ? eop_cnt + 4'h1 : 4'h0;
		if (eop_act && eop_cnt == EOP_CYC - 4'h1) begin
			end_flag <= 1'b1;
			if (mode[MODE_TRANSFER_END_IRQ_ENABLE]) irq_o <= 1'b1;
		end
		if (!dma_ack_in_n_i) drq_o <= 1'b0;
		else if (!dk_q && !mode[MODE_BURST_DMA_SELECT]) drq_o <= act;
		if (byte_end) bytes <= bytes + 8'h01;
		if (!wr_q && wr_n_i && !dma_ack_in_n_i) last_wr <= data_i;
		if (!wr_q && wr_n_i && !cs_n_i) begin
			acc_cnt <= acc_cnt + 1;
			case (addr_i)
				3'h1: icr <= data_i;
				3'h2: mode <= data_i; // role and enables kept
				3'h3: tcmd <= data_i;
				3'h4: sel_mask <= data_i;
				default: ;
			endcase
			if (addr_i >= 3'h5 && mode[MODE_DMA_ENABLE]) begin
				act <= 1'b1;
				drq_o <= 1'b1;
				bytes <= 8'h00;
			end
			if (addr_i == 3'h2 && !data_i[MODE_DMA_ENABLE]) begin
				act <= 1'b0;
				drq_o <= 1'b0;
				end_flag <= 1'b0;
			end
		end
		if (!rd_q && rd_n_i && !cs_n_i) begin
			acc_cnt <= acc_cnt + 1;
			if (addr_i == 3'h7) irq_o <= 1'b0;
		end
		if (!rst_n_i) begin
			mode <= 8'h00;
			act <= 1'b0;
			drq_o <= 1'b0;
			irq_o <= 1'b0;
			end_flag <= 1'b0;
		end
	end
endmodule

// file: smh_scsi_host_test.sv
`timescale 1ns/10ps
module smh_scsi_host_test;
	import smh_pkg::*;
	logic core_clk_i = 1'b0, nrst_i = 1'b0, sw_wr_i = 1'b0, sw_rd_i = 1'b0, ce_i = 1'b1;
	logic [3:0] sw_addr_i = 4'h0;
	logic [7:0] sw_wdata_i = 8'h00, sw_rdata_o, dev_data_i, dev_data_o, d;
	logic [2:0] dev_addr_o;
	logic dev_cs_n_o, read_strobe_n_o, write_strobe_n_o, dev_data_oe_o, dma_req_i, dma_ack_n_o;
	logic transfer_end_n_o, dev_ready_i, dev_irq_i, dev_reset_n_o;
	int error_cnt = 0, cmp_count = 0;
	smh_phase_e codes[6] = '{PH_DATA_OUT, PH_COMMAND, PH_MSG_OUT, PH_DATA_IN, PH_STATUS, PH_MSG_IN};
	// 50 MHz core clock
	always #10 core_clk_i = ~core_clk_i;
	smh_scsi_host dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
		.sw_rdata_o(sw_rdata_o), .dev_cs_n_o(dev_cs_n_o), .dev_addr_o(dev_addr_o),
		.read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
		.dev_data_i(dev_data_i), .dev_data_o(dev_data_o), .dev_data_oe_o(dev_data_oe_o),
		.dma_req_i(dma_req_i), .dma_ack_n_o(dma_ack_n_o), .transfer_end_n_o(transfer_end_n_o),
		.dev_ready_i(dev_ready_i), .dev_irq_i(dev_irq_i), .dev_reset_n_o(dev_reset_n_o));
	smh_dev_model dev_u (.clk_i(core_clk_i), .rst_n_i(dev_reset_n_o), .cs_n_i(dev_cs_n_o),
		.addr_i(dev_addr_o), .rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_n_o),
		.data_i(dev_data_o), .data_o(dev_data_i), .drq_o(dma_req_i), .dma_ack_in_n_i(dma_ack_n_o),
		.eop_n_i(transfer_end_n_o), .ready_o(dev_ready_i), .irq_o(dev_irq_i));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle software strobes, launched just after a rising edge
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		sw_wr_i <= 1'b1;
		sw_addr_i <= a;
		sw_wdata_i <= v;
		@(posedge core_clk_i);
		sw_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge core_clk_i);
		sw_rd_i <= 1'b1;
		sw_addr_i <= a;
		@(posedge core_clk_i);
		sw_rd_i <= 1'b0;
		#1 v = sw_rdata_o;
	endtask
	// Poll until neither an access nor a DMA run is pending
	task automatic idle();
		int n;
		n = 0;
		d = 8'h11;
		while (d[STAT_BUSY] !== 1'b0 || d[STAT_DMA] !== 1'b0) begin
			rd(REG_STATUS, d);
			n++;
			if (n > 300) begin
				error_cnt++;
				summarize();
			end
		end
	endtask
	task automatic dcmd(input logic [3:0] c, input logic [7:0] v);
		wr(REG_DEV_WDATA, v);
		wr(REG_CMD, {4'h0, c});
		idle();
	endtask
	// Refused command: flag set, and a wrong access would have finished within the wait
	task automatic refuse(input logic [3:0] c, input logic [7:0] v);
		int n0;
		n0 = dev_u.acc_cnt;
		wr(REG_DEV_WDATA, v);
		wr(REG_CMD, {4'h0, c});
		repeat (12) @(posedge core_clk_i);
		rd(REG_STATUS, d);
		chk({7'h00, d[STAT_REFUSED]}, 8'h01);
		chk(8'(dev_u.acc_cnt - n0), 8'h00);
	endtask
	initial begin
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		foreach (codes[i]) begin
			dcmd({1'b0, PORT_TARGET_PHASE_COMMAND}, {5'h00, codes[i]});
			dcmd({1'b1, PORT_TARGET_PHASE_COMMAND}, 8'h00);
			rd(REG_DEV_RDATA, d);
			chk(d, {5'h00, codes[i]});
		end
		refuse({1'b0, PORT_TARGET_PHASE_COMMAND}, {5'h00, PH_UNSPEC_A});
		refuse({1'b0, PORT_TARGET_PHASE_COMMAND}, {5'h00, PH_UNSPEC_B});
		$display("test phase codes done");
		for (int p = 5; p < 8; p++) refuse({1'b0, 3'(p)}, 8'h00);
		dcmd({1'b0, PORT_OPERATING_CONTROL}, 8'h0A);
		refuse({1'b0, PORT_TARGET_RECEIVE_START}, 8'h00);
		refuse({1'b0, PORT_SEND_TRANSFER_START}, 8'h00);
		$display("test refusals done");
		wr(REG_DMA_COUNT, 8'h02);
		dcmd({1'b0, PORT_INITIATOR_RECEIVE_START}, 8'hA5);
		rd(REG_DMA_RDATA, d);
		chk(d, 8'hC3);
		chk(dev_u.bytes, 8'h02);
		chk({7'h00, dev_u.end_flag}, 8'h01);
		rd(REG_STATUS, d);
		chk({7'h00, d[STAT_IRQ]}, 8'h01);
		dcmd({1'b1, PORT_INITIATOR_RECEIVE_START}, 8'h00);
		rd(REG_STATUS, d);
		chk({7'h00, d[STAT_IRQ]}, 8'h00);
		chk({7'h00, d[STAT_DRQ]}, 8'h01);
		dcmd({1'b0, PORT_OPERATING_CONTROL}, 8'h00);
		chk({7'h00, dev_u.end_flag}, 8'h00);
		rd(REG_STATUS, d);
		chk({7'h00, d[STAT_DRQ]}, 8'h00);
		$display("test normal receive done");
		dcmd({1'b0, PORT_ICR}, 8'h01);
		dcmd({1'b0, PORT_OPERATING_CONTROL}, 8'h82);
		wr(REG_DMA_WDATA, 8'h5A);
		wr(REG_DMA_COUNT, 8'h03);
		dcmd({1'b0, PORT_SEND_TRANSFER_START}, 8'hFF);
		chk(dev_u.bytes, 8'h03);
		chk(dev_u.last_wr, 8'h5A);
		chk({7'h00, dev_u.end_flag}, 8'h01);
		$display("test burst send done");
		dcmd({1'b0, PORT_OPERATING_CONTROL}, 8'h42);
		refuse({1'b0, PORT_INITIATOR_RECEIVE_START}, 8'h00);
		wr(REG_DMA_COUNT, 8'h01);
		dcmd({1'b0, PORT_TARGET_RECEIVE_START}, 8'h00);
		chk(dev_u.bytes, 8'h01);
		rd(REG_DMA_RDATA, d);
		chk(d, 8'hC3);
		$display("test target receive done");
		rd(4'hF, d);
		chk(d, 8'h00);
		wr(REG_HOST_CTRL, 8'h01);
		@(posedge core_clk_i);
		#1 chk({7'h00, dev_reset_n_o}, 8'h00);
		wr(REG_HOST_CTRL, 8'h00);
		@(posedge core_clk_i);
		#1 chk(dev_u.mode, 8'h00);
		// Clock enable low must drop a software write entirely
		ce_i <= 1'b0;
		wr(REG_DMA_WDATA, 8'h3C);
		ce_i <= 1'b1;
		rd(REG_DMA_WDATA, d);
		chk(d, 8'h5A);
		$display("test misc done");
		summarize();
	end
endmodule
bind smh_scsi_host smh_scsi_host_asserts chk_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
	.dev_cs_n_o(dev_cs_n_o), .dev_addr_o(dev_addr_o), .read_strobe_n_o(read_strobe_n_o),
	.write_strobe_n_o(write_strobe_n_o), .dev_data_o(dev_data_o),
	.dev_data_oe_o(dev_data_oe_o), .dma_ack_n_o(dma_ack_n_o),
	.transfer_end_n_o(transfer_end_n_o));
